/* hdl/wsw_pkg.sv */
// Package for the wait/stop/wake controller: states, context codes,
// carrier structs and timing constants.
// Assumes one clock at 50 MHz and an active-low asynchronous reset.
package wsw_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS  = 20_000;
  // Default oscillator stabilisation time after leaving stop, in ns
  localparam int unsigned STAB_TIME_NS   = 2_000;
  localparam int unsigned STAB_CYCLES    =
    (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STAB_CNT_W     = 16;
  // Global enable position in the interrupt option byte
  localparam int unsigned GIE_BIT        = 4;
  localparam logic [7:0]  IOR_RESET      = 8'h00;

  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_STOP  = 3'b010,
    ST_STAB  = 3'b011,
    ST_WAKE  = 3'b100
  } pm_state_e;

  typedef enum logic [1:0]
  {
    CTX_MAIN = 2'b00,
    CTX_IRQ  = 2'b01,
    CTX_NMI  = 2'b10
  } core_ctx_e;

  // Wake-up action handed to the core
  typedef enum logic [1:0]
  {
    ACT_NONE     = 2'b00,
    ACT_SERVICE  = 2'b01,
    ACT_RESUME   = 2'b10,
    ACT_NMI_FIRST = 2'b11
  } wake_act_e;

  typedef struct packed
  {
    logic      wait_ins;
    logic      stop_ins;
    core_ctx_e ctx;
  } core_req_s;

  typedef struct packed
  {
    logic nmi;
    logic irq;
  } irq_req_s;

endpackage

/* hdl/wait_stop_wake_control.sv */
// Wait/stop/wake controller sitting between the core and its clocks.
// Assumes core requests and interrupt lines are synchronous to mclk_i and
// that watchdog reset and pin reset are merged onto rstn_i outside.
//
// How it works
// - Wait instruction freezes core, peripherals run
// - Selected oscillator keeps running during wait
// - Timer or peripheral interrupt ends wait
// - Reset during wait gives full reset
// - Wake from wait resumes without delay
// - Watchdog active turns stop into wait
// - Stop halts oscillator until interrupt/reset
// - RAM and peripheral registers are untouched
// - Pin reset during stop gives full reset
// - Wake from stop waits for oscillator settle
// - Wake never changes oscillator selection
// - Main context: service irq, then continue
// - NMI context: resume directly, no service
// - Irq context, normal wake: continue routine
// - Irq context, NMI wake: NMI handler first
// - Global enable low: no interrupt wakes
// - Pending enabled request skips low power entry
// - Global enable is option byte bit 4
`timescale 1ns/1ps
module wait_stop_wake_control
  import wsw_pkg::*;
#(
  parameter int unsigned STAB_COUNT = STAB_CYCLES
)
(
  input  wire logic      mclk_i,
  input  wire logic      rstn_i,
  input  wire core_req_s core_req_i,
  input  wire irq_req_s  irq_i,
  input  wire logic      ior_we_i,
  input  wire logic [7:0] ior_data_i,
  input  wire logic      wdg_hw_i,
  input  wire logic      wdg_sw_en_i,
  input  wire logic      aux_osc_sel_i,
  output logic           core_halt_o,
  output logic           osc_run_o,
  output logic           osc_aux_sel_o,
  output logic           periph_clk_en_o,
  output logic           wake_o,
  output wake_act_e      wake_act_o,
  output logic           skip_o,
  output logic           global_irq_enable_o,
  output pm_state_e      state_o
);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt option byte: only the global enable bit matters here
  logic        gie_reg;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      gie_reg <= IOR_RESET[GIE_BIT];
    else if (ior_we_i)
      gie_reg <= ior_data_i[GIE_BIT];
  end
  assign global_irq_enable_o = gie_reg;

  ////////////////////////////////////////////////////////////////////////
  // Request decode
  logic stop_allowed;
  logic pending;
  logic wake_src;
  logic enter_wait;
  logic enter_stop;

  assign stop_allowed = !(wdg_hw_i || wdg_sw_en_i);
  // NMI is always enabled as an interrupt, maskables need the global bit
  assign pending      = irq_i.nmi || (gie_reg && irq_i.irq);
  // With the global bit low nothing wakes the part, not even the NMI
  assign wake_src     = gie_reg && (irq_i.nmi || irq_i.irq);
  assign enter_wait   = !pending &&
    (core_req_i.wait_ins || (core_req_i.stop_ins && !stop_allowed));
  assign enter_stop   = !pending && core_req_i.stop_ins && stop_allowed;
  assign skip_o       = pending &&
    (core_req_i.wait_ins || core_req_i.stop_ins);

  ////////////////////////////////////////////////////////////////////////
  // Power state machine
  pm_state_e              state_reg;
  pm_state_e              state_next;
  logic [STAB_CNT_W-1:0]  stab_reg;
  core_ctx_e              ctx_reg;
  logic                   wnmi_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (enter_stop)
          state_next = ST_STOP;
        else if (enter_wait)
          state_next = ST_WAIT;
      ST_WAIT:
        if (wake_src)
          state_next = ST_WAKE;
      ST_STOP:
        if (wake_src)
          state_next = ST_STAB;
      ST_STAB:
        if (stab_reg == STAB_CNT_W'(0))
          state_next = ST_WAKE;
      ST_WAKE:
        state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  // Any reset, pin or watchdog, lands here and restarts from run
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end
  assign state_o = state_reg;

  // A count of zero wraps to the longest settle; keep it above zero
  // Length is a parameter since the settle time depends on the crystal
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      stab_reg <= '0;
    else if (state_reg == ST_STOP && wake_src)
      stab_reg <= STAB_CNT_W'(STAB_COUNT - 1);
    else if (state_reg == ST_STAB && stab_reg != STAB_CNT_W'(0))
      stab_reg <= stab_reg - STAB_CNT_W'(1);
  end

  // Context captured at entry, wake kind captured at wake
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctx_reg <= CTX_MAIN;
    else if (state_reg == ST_RUN && (enter_wait || enter_stop))
      ctx_reg <= core_req_i.ctx;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wnmi_reg <= 1'b0;
    else if ((state_reg == ST_WAIT || state_reg == ST_STOP) && wake_src)
      wnmi_reg <= irq_i.nmi;
  end

  ////////////////////////////////////////////////////////////////////////
  // Resume action
  wake_act_e act_next;
  always_comb
  begin
    case (ctx_reg)
      CTX_MAIN: act_next = ACT_SERVICE;
      CTX_NMI:  act_next = ACT_RESUME;
      CTX_IRQ:  act_next = wnmi_reg ? ACT_NMI_FIRST
                                    : ACT_RESUME;
      default:  act_next = ACT_RESUME;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wake_o     <= 1'b0;
      wake_act_o <= ACT_NONE;
    end
    else
    begin
      wake_o     <= (state_reg == ST_WAKE);
      wake_act_o <= (state_reg == ST_WAKE) ? act_next : ACT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock and core controls. Nothing here touches RAM or peripheral
  // registers, so their contents ride through both modes unchanged.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      core_halt_o     <= 1'b0;
      osc_run_o       <= 1'b1;
      periph_clk_en_o <= 1'b1;
    end
    else
    begin
      core_halt_o     <= (state_next != ST_RUN);
      osc_run_o       <= (state_next != ST_STOP);
      periph_clk_en_o <= (state_next == ST_RUN ||
                          state_next == ST_WAIT);
    end
  end
  // Selection passes straight through; wake never alters it
  assign osc_aux_sel_o = aux_osc_sel_i;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_STOP_BLOCKED: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_RUN && core_req_i.stop_ins && !stop_allowed && !pending)
    |=> state_reg == ST_WAIT)
    else $error("stop entered with watchdog");
  AST_WAIT_WAKE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_WAIT && wake_src) |=> ##1 wake_o)
    else $error("wait wake slow");
  AST_STOP_OSC: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STOP) |-> !osc_run_o && core_halt_o)
    else $error("osc running in stop");
  AST_WAIT_OSC: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_WAIT) |-> osc_run_o && periph_clk_en_o)
    else $error("osc stopped in wait");
  AST_NO_WAKE_GIE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_WAIT && !gie_reg) |=> state_reg == ST_WAIT)
    else $error("woke with enable low");
  AST_SKIP: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_RUN && pending) |=> state_reg == ST_RUN)
    else $error("entered with pending irq");
  AST_NMI_CTX: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wake_o && ctx_reg == CTX_NMI) |-> wake_act_o == ACT_RESUME)
    else $error("nmi context serviced");
  AST_STAB_LEN: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STOP && wake_src && STAB_COUNT == 2)
    |=> state_reg == ST_STAB ##1 state_reg == ST_STAB ##1 state_reg == ST_WAKE)
    else $error("stabilisation length wrong");
  AST_GIE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    ior_we_i |=> gie_reg == $past(ior_data_i[GIE_BIT]))
    else $error("global enable not written");

  // Cycles spent settling; read only by the length checks below
  logic [STAB_CNT_W-1:0] settle_reg;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      settle_reg <= '0;
    else if (state_reg == ST_STAB)
      settle_reg <= settle_reg + STAB_CNT_W'(1);
    else
      settle_reg <= '0;
  end

  // Entry and clock checks
  // Reset is checked without a disable so that it is seen at all
  AST_RESET_IDLE: assert property (
    @(posedge mclk_i)
    !rstn_i |=> state_reg == ST_RUN && !core_halt_o && osc_run_o &&
      periph_clk_en_o && !wake_o)
    else $error("state not idle after reset");
  AST_WAIT_ENTRY: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_RUN && core_req_i.wait_ins && !core_req_i.stop_ins &&
     !pending) |=> state_reg == ST_WAIT && core_halt_o)
    else $error("wait not entered");
  AST_STOP_ENTRY: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_RUN && core_req_i.stop_ins && !wdg_hw_i &&
     !wdg_sw_en_i && !pending) |=> state_reg == ST_STOP && !osc_run_o)
    else $error("stop not entered");
  AST_HALT_MATCH: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    core_halt_o == (state_reg != ST_RUN))
    else $error("halt does not follow state");
  AST_IRQ_WAKE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_WAIT && gie_reg && irq_i.irq) |=> state_reg == ST_WAKE)
    else $error("interrupt did not end wait");
  AST_STOP_WAKE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STOP && wake_src) |=> state_reg == ST_STAB && osc_run_o)
    else $error("stop wake skipped settling");
  AST_STAB_OSC: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STAB) |-> osc_run_o && core_halt_o)
    else $error("core ran while settling");
  AST_STOP_PCLK: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STOP) |-> !periph_clk_en_o)
    else $error("peripheral clock on in stop");
  AST_STOP_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STOP && !gie_reg) |=> state_reg == ST_STOP)
    else $error("left stop with enable low");
  AST_SKIP_STAY: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_RUN && skip_o) |=> state_reg == ST_RUN && !core_halt_o)
    else $error("skipped request still halted");
  AST_AUX_PASS: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    osc_aux_sel_o == aux_osc_sel_i)
    else $error("oscillator selection altered");

  // Resume checks
  AST_WAKE_ONCE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  AST_WAKE_RUN: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    wake_o |-> state_reg == ST_RUN && !core_halt_o)
    else $error("core still halted at wake");
  AST_ACT_IDLE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !wake_o |-> wake_act_o == ACT_NONE)
    else $error("action shown without wake");
  AST_MAIN_SERVICE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wake_o && ctx_reg == CTX_MAIN) |-> wake_act_o == ACT_SERVICE)
    else $error("main context not serviced");
  AST_IRQ_RESUME: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wake_o && ctx_reg == CTX_IRQ && !wnmi_reg)
    |-> wake_act_o == ACT_RESUME)
    else $error("irq context not resumed");
  AST_IRQ_NMI: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wake_o && ctx_reg == CTX_IRQ && wnmi_reg)
    |-> wake_act_o == ACT_NMI_FIRST)
    else $error("nmi handler not first");

  // Settle length checks, any parameter value
  AST_STAB_EXACT: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STAB && settle_reg == STAB_CNT_W'(STAB_COUNT - 1))
    |=> state_reg == ST_WAKE)
    else $error("settle longer than count");
  AST_STAB_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == ST_STAB && settle_reg < STAB_CNT_W'(STAB_COUNT - 1))
    |=> state_reg == ST_STAB)
    else $error("settle shorter than count");

endmodule // wait_stop_wake_control

/* tb/core_model.sv */
// Core and interrupt source model: instruction pulses, request levels.
// Assumes the bench clock on clk_i and the controller's skip flag.
`timescale 1ns/1ps
module core_model
  import wsw_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic skip_i,
  output core_req_s req_o,
  output irq_req_s  irq_o
);
  logic skipped;
  initial
  begin
    req_o   = '0;
    irq_o   = '0;
    skipped = 1'b0;
  end
  // One instruction, one cycle wide; ctx stays put for the whole stay
  task automatic issue(input logic stp, input core_ctx_e ctx);
    @(posedge clk_i);
    req_o <= '{wait_ins: !stp, stop_ins: stp, ctx: ctx};
    @(posedge clk_i);
    skipped = skip_i;
    req_o.wait_ins <= 1'b0;
    req_o.stop_ins <= 1'b0;
  endtask
  // Requests are levels, held until the core drops them
  task automatic raise(input logic nmi, input logic irq);
    @(posedge clk_i);
    irq_o <= '{nmi: nmi, irq: irq};
  endtask
endmodule // core_model

/* tb/tb_top.sv */
// Bench for the wait/stop/wake controller with a core model.
// Assumes the package constants and a 50 MHz clock.
`timescale 1ns/1ps
module tb_top
  import wsw_pkg::*;
;
  localparam int unsigned STAB = 2;
  logic       mclk_i, rstn_i, ior_we_i, wdg_hw_i, wdg_sw_en_i;
  logic       aux_osc_sel_i, core_halt_o, osc_run_o, osc_aux_sel_o;
  logic       periph_clk_en_o, wake_o, skip_o, global_irq_enable_o;
  logic [7:0] ior_data_i;
  core_req_s  core_req_i;
  irq_req_s   irq_i;
  wake_act_e  wake_act_o;
  pm_state_e  state_o;
  int         error_cnt, compares, seed, n;
  int         exp_q[$];

  wait_stop_wake_control #(.STAB_COUNT(STAB)) i_dut (.mclk_i, .rstn_i,
    .core_req_i, .irq_i, .ior_we_i, .ior_data_i, .wdg_hw_i, .wdg_sw_en_i,
    .aux_osc_sel_i, .core_halt_o, .osc_run_o, .osc_aux_sel_o,
    .periph_clk_en_o, .wake_o, .wake_act_o, .skip_o,
    .global_irq_enable_o, .state_o);
  core_model i_core (.clk_i(mclk_i), .skip_i(skip_o), .req_o(core_req_i),
    .irq_o(irq_i));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic set_ior(input logic [7:0] b);
    @(posedge mclk_i);
    ior_we_i   <= 1'b1;
    ior_data_i <= b;
    @(posedge mclk_i);
    ior_we_i <= 1'b0;
    #1;
    chk("gie", global_irq_enable_o, b[4]);
  endtask
  // Wake from wait or stop; m: 0 wait, 1 stop, 2/3 stop under watchdog
  task automatic run_one(input int c, input int s, input int m);
    exp_q.push_back((c == 2) ? 2 : (c == 1) ? (s ? 3 : 2) : 1);
    @(posedge mclk_i);
    wdg_hw_i      <= (m == 2);
    wdg_sw_en_i   <= (m == 3);
    aux_osc_sel_i <= 1'($random(seed));
    i_core.issue(m != 0, core_ctx_e'(c));
    #1;
    chk("state", state_o, (m == 1) ? ST_STOP : ST_WAIT);
    chk("noskip", i_core.skipped, 0);
    chk("halt", core_halt_o, 1);
    chk("osc", osc_run_o, m != 1);
    chk("pclk", periph_clk_en_o, m != 1);
    chk("aux", osc_aux_sel_o, aux_osc_sel_i);
    i_core.raise(s, !s);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (wake_o !== 1'b1 && n < 50);
    chk("wake", wake_o, 1);
    chk("act", wake_act_o, exp_q.pop_front());
    chk("resume", core_halt_o, 0);
    if (m == 1)
      chk("stab", n, STAB + 2);
    else
      chk("lat", n, 2);
    i_core.raise(0, 0);
    #1;
    chk("run", state_o, ST_RUN);
  endtask

  initial
  begin
    mclk_i = 0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial
  begin
    #400_000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    seed = 32'h4abe_e4a7;
    {rstn_i, ior_we_i, wdg_hw_i, wdg_sw_en_i, aux_osc_sel_i} = '0;
    ior_data_i = 8'h00;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    set_ior(8'hEF);
    set_ior(8'h10);
    for (int c = 0; c < 3; c++)
      for (int s = 0; s < 2; s++)
        for (int m = 0; m < 4; m++)
          run_one(c, s, m);
    $display("Wake tests done");
    i_core.raise(0, 1);
    i_core.issue(0, CTX_MAIN);
    #1;
    chk("skip", i_core.skipped, 1);
    chk("noentry", state_o, ST_RUN);
    i_core.raise(0, 0);
    $display("Skip test done");
    // Watchdog left on by the last wake test would turn stop into wait
    @(posedge mclk_i);
    {wdg_hw_i, wdg_sw_en_i} <= 2'b00;
    for (int m = 0; m < 2; m++)
    begin
      set_ior(8'hEF);
      i_core.issue(m, CTX_MAIN);
      i_core.raise(1, 1);
      repeat (10) @(posedge mclk_i);
      #1;
      chk("nowake", state_o, m ? ST_STOP : ST_WAIT);
      i_core.raise(0, 0);
      rstn_i <= 1'b0;
      #1;
      chk("rst", {state_o, core_halt_o, osc_run_o}, 5'b00001);
      @(posedge mclk_i);
      rstn_i <= 1'b1;
      set_ior(8'h10);
    end
    $display("Disable and reset tests done");
    close_out();
  end
endmodule // tb_top
